// ==== dv/pvp_assertions.sv ====
module pvp_assertions
    import pvp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] mode_cmd,
    input wire logic move_start,
    input wire logic move_method,
    input wire logic homed,
    input wire logic [3:0] op_state,
    input wire logic outputs_reassigned,
    input wire logic [31:0] ctrl_v_max,
    input wire logic [31:0] ramp_v_max,
    input wire logic stop_halt,
    input wire logic stop_quick,
    input wire logic stop_error,
    input wire logic standstill,
    input wire logic target_reached,
    input wire logic no_fault_output,
    input wire logic active_output,
    input wire logic [1:0] mode_active,
    input wire logic mode_ended,
    input wire logic signed [31:0] vel_setpoint,
    input wire logic [31:0] pos_speed,
    input wire logic move_go,
    input wire logic abs_refused
);
    timeunit 1ns;
    timeprecision 1ns;
    logic signed [32:0] lim;

    // The tighter maximum bounds the speed both ways, so both signs are checked.
    assign lim = {1'b0, (ctrl_v_max < ramp_v_max) ? ctrl_v_max : ramp_v_max};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // A stop only counts once the motor stands still.
    sequence vel_stop_seq;
        mode_active == 2'h1 && op_state == 4'h6 && standstill && (stop_halt || stop_quick || stop_error) && !mode_ended;
    endsequence
    sequence pos_stop_seq;
        mode_active == 2'h2 && op_state == 4'h6 && standstill && target_reached && !mode_ended;
    endsequence

    nofault_state_a: assert property (
        $past(rst_n) |-> no_fault_output == ($past(op_state) inside {4'h4, 4'h5, 4'h6} && !$past(outputs_reassigned)))
        else $error("no fault output wrong for state");
    active_state_a: assert property (
        $past(rst_n) |-> active_output == ($past(op_state) == 4'h6 && !$past(outputs_reassigned)))
        else $error("active output wrong for state");
    vel_clamp_a: assert property (
        $stable(ctrl_v_max) && $stable(ramp_v_max) |-> vel_setpoint <= lim && vel_setpoint >= -lim)
        else $error("velocity setpoint above limit");
    vel_end_a: assert property (vel_stop_seq |=> mode_ended)
        else $error("velocity mode did not end");
    pos_end_a: assert property (pos_stop_seq |=> mode_ended)
        else $error("position mode did not end");
    mode_by_cmd_a: assert property (
        mode_active != 2'h0 && $past(mode_active) == 2'h0 |-> $past(mode_cmd, 2) == mode_active)
        else $error("mode entered without command");
    abs_refuse_a: assert property (
        mode_active == 2'h2 && !mode_ended && move_start && move_method && !homed |=> abs_refused && !move_go)
        else $error("absolute move accepted unhomed");
    speed_hold_a: assert property (!move_go |-> $stable(pos_speed) && pos_speed != 32'h0)
        else $error("move speed changed between moves");
endmodule

// ==== dv/pvp_master.sv ====
module pvp_master
    import pvp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [31:0] prsp_rdata,
    input wire logic prsp_valid,
    input wire logic prsp_err,
    output logic preq_wr,
    output logic preq_rd,
    output logic [15:0] preq_addr,
    output logic [31:0] preq_wdata,
    output logic [1:0] mode_cmd,
    output logic move_start,
    output logic move_method,
    output logic homed
);
    timeunit 1ns;
    timeprecision 1ns;

    // The controller starts quiet and without a zero point.
    initial begin
        {preq_wr, preq_rd, preq_addr, preq_wdata, mode_cmd, move_start, move_method, homed} = '0;
    end

    // Released address and data are inverted so stale values cannot pass.
    task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q,
                          output logic e);
        @(posedge sys_clk);
        {preq_wr, preq_rd, preq_addr, preq_wdata} <= {wr, !wr, a, d};
        @(posedge sys_clk);
        {preq_wr, preq_rd, preq_addr, preq_wdata} <= {2'b00, ~a, ~d};
        // The answer stands only for the cycle after the request is taken, so it is read mid-cycle.
        @(negedge sys_clk);
        q = prsp_valid ? prsp_rdata : 'x;
        e = prsp_valid ? prsp_err : 1'bx;
    endtask

    // Modes start only when commanded here.
    task automatic command(input logic [1:0] m);
        @(posedge sys_clk);
        mode_cmd <= m;
        @(posedge sys_clk);
        mode_cmd <= PVP_CMD_NONE;
    endtask

    task automatic move(input logic meth);
        @(posedge sys_clk);
        {move_start, move_method} <= {1'b1, meth};
        @(posedge sys_clk);
        move_start <= 1'b0;
    endtask

    // Homing stands in for defining the zero point.
    task automatic home();
        @(posedge sys_clk);
        homed <= 1'b1;
    endtask
endmodule

// ==== dv/pvp_top_tb.sv ====
module pvp_top_tb
    import pvp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_n, preq_wr, preq_rd, prsp_valid, prsp_err, move_start, move_method, rel_reference, homed, e;
    logic outputs_reassigned, stop_halt, stop_quick, stop_error, standstill, target_reached;
    logic no_fault_output, active_output, mode_ended, move_go, abs_refused;
    logic [1:0] mode_cmd, mode_active;
    logic [3:0] op_state;
    logic [15:0] preq_addr;
    logic [31:0] preq_wdata, prsp_rdata, ctrl_v_max, ramp_v_max, pos_speed, q;
    logic signed [31:0] pos_min, pos_max, actual_pos, vel_setpoint, pos_setpoint;
    int n_errors = 0;
    int n_checks = 0;
    // Rows hold {reassigned, operating state, no fault, active}.
    logic [6:0] rows [8] = '{7'h00, 7'h0C, 7'h12, 7'h16, 7'h1B, 7'h1C, 7'h3C, 7'h58};

    pvp_top DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .preq_wr(preq_wr), .preq_rd(preq_rd), .preq_addr(preq_addr),
        .preq_wdata(preq_wdata), .prsp_rdata(prsp_rdata), .prsp_valid(prsp_valid), .prsp_err(prsp_err),
        .mode_cmd(mode_cmd), .move_start(move_start), .move_method(move_method), .rel_reference(rel_reference),
        .homed(homed), .op_state(op_state), .outputs_reassigned(outputs_reassigned), .ctrl_v_max(ctrl_v_max),
        .ramp_v_max(ramp_v_max), .pos_min(pos_min), .pos_max(pos_max), .actual_pos(actual_pos),
        .stop_halt(stop_halt), .stop_quick(stop_quick), .stop_error(stop_error), .standstill(standstill),
        .target_reached(target_reached), .no_fault_output(no_fault_output), .active_output(active_output),
        .mode_active(mode_active), .mode_ended(mode_ended), .vel_setpoint(vel_setpoint),
        .pos_setpoint(pos_setpoint), .pos_speed(pos_speed), .move_go(move_go), .abs_refused(abs_refused)
    );
    pvp_master u_m (
        .sys_clk(sys_clk), .prsp_rdata(prsp_rdata), .prsp_valid(prsp_valid), .prsp_err(prsp_err),
        .preq_wr(preq_wr), .preq_rd(preq_rd), .preq_addr(preq_addr), .preq_wdata(preq_wdata),
        .mode_cmd(mode_cmd), .move_start(move_start), .move_method(move_method), .homed(homed)
    );

    // Clock of 100 ns period.
    always #50 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic give_verdict();
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The run needs under a hundred cycles, so 4000 means a hang.
    initial begin
        #400000;
        n_errors++;
        give_verdict();
    end

    // Reset, status table, then the mode sequences.
    initial begin
        {rst_n, rel_reference, outputs_reassigned, stop_halt, stop_quick, stop_error, standstill} = '0;
        {target_reached, op_state, actual_pos, ctrl_v_max, ramp_v_max} = '0;
        {pos_min, pos_max} = {32'hFFFFD8F0, 32'h00002710};
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(0);
        check("pos_speed", pos_speed, 32'h3C);
        u_m.access(1'b0, PVP_OFS_VM_TGT_SPEED, 32'h0, q, e);
        check("vm_speed", q, 32'h0);
        u_m.access(1'b0, PVP_OFS_PM_TGT_SPEED, 32'h0, q, e);
        check("pm_speed", q, 32'h3C);
        u_m.access(1'b0, 16'h1B20, 32'h0, q, e);
        check("unmapped", e, 1'b1);
        foreach (rows[i]) begin
            @(posedge sys_clk);
            {outputs_reassigned, op_state} <= rows[i][6:2];
            settle(1);
            check("no_fault", no_fault_output, rows[i][1]);
            check("active", active_output, rows[i][0]);
        end
        @(posedge sys_clk);
        {outputs_reassigned, op_state} <= 5'h05;
        u_m.command(PVP_CMD_VELOCITY);
        settle(3);
        check("refused", mode_active, 2'h0);
        @(posedge sys_clk);
        {op_state, ctrl_v_max, ramp_v_max} <= {4'h6, 32'h64, 32'h32};
        u_m.access(1'b1, PVP_OFS_VM_TGT_SPEED, 32'hFFFFFF38, q, e);
        u_m.command(PVP_CMD_VELOCITY);
        settle(2);
        check("vel_mode", mode_active, 2'h1);
        check("clamped", vel_setpoint, 32'hFFFFFFCE);
        u_m.access(1'b1, PVP_OFS_VM_TGT_SPEED, 32'h1E, q, e);
        settle(0);
        check("vel_now", vel_setpoint, 32'h1E);
        @(posedge sys_clk);
        standstill <= 1'b1;
        settle(2);
        check("vel_stays", mode_active, 2'h1);
        @(posedge sys_clk);
        stop_halt <= 1'b1;
        settle(1);
        check("vel_end", mode_ended, 1'b1);
        @(posedge sys_clk);
        {stop_halt, standstill} <= 2'b00;
        u_m.access(1'b1, PVP_OFS_PM_TGT_POS, 32'h3E8, q, e);
        u_m.access(1'b1, PVP_OFS_PM_TGT_SPEED, 32'h80, q, e);
        u_m.command(PVP_CMD_POSITION);
        settle(2);
        u_m.move(PVP_METHOD_ABSOLUTE);
        settle(0);
        check("refuse", {abs_refused, move_go}, 2'b10);
        u_m.home();
        u_m.move(PVP_METHOD_ABSOLUTE);
        settle(0);
        check("abs_goal", pos_setpoint, 32'h3E8);
        // The move speed is held to the tighter maximum of 0x32.
        check("abs_speed", pos_speed, 32'h32);
        u_m.access(1'b1, PVP_OFS_PM_TGT_SPEED, 32'h28, q, e);
        settle(0);
        check("speed_later", pos_speed, 32'h32);
        u_m.access(1'b1, PVP_OFS_PM_TGT_SPEED, 32'h0, q, e);
        u_m.access(1'b0, PVP_OFS_PM_TGT_SPEED, 32'h0, q, e);
        check("zero_speed", q, 32'h28);
        @(posedge sys_clk);
        {actual_pos, rel_reference} <= {32'h5, PVP_REF_ACTUAL_POS};
        u_m.move(PVP_METHOD_RELATIVE);
        settle(0);
        check("rel_goal", pos_setpoint, 32'h3ED);
        check("rel_speed", pos_speed, 32'h28);
        @(posedge sys_clk);
        rel_reference <= PVP_REF_PREV_TARGET;
        u_m.move(PVP_METHOD_RELATIVE);
        settle(0);
        check("prev_goal", pos_setpoint, 32'h7D5);
        u_m.access(1'b1, PVP_OFS_PM_TGT_POS, 32'h3000, q, e);
        u_m.move(PVP_METHOD_ABSOLUTE);
        settle(0);
        check("pos_bound", pos_setpoint, 32'h2710);
        @(posedge sys_clk);
        {standstill, target_reached} <= 2'b11;
        settle(1);
        check("pos_end", mode_ended, 1'b1);
        give_verdict();
    end
endmodule

bind pvp_top pvp_assertions u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .mode_cmd(mode_cmd), .move_start(move_start), .move_method(move_method),
    .homed(homed), .op_state(op_state), .outputs_reassigned(outputs_reassigned), .ctrl_v_max(ctrl_v_max),
    .ramp_v_max(ramp_v_max), .stop_halt(stop_halt), .stop_quick(stop_quick), .stop_error(stop_error),
    .standstill(standstill), .target_reached(target_reached), .no_fault_output(no_fault_output),
    .active_output(active_output), .mode_active(mode_active), .mode_ended(mode_ended),
    .vel_setpoint(vel_setpoint), .pos_speed(pos_speed), .move_go(move_go), .abs_refused(abs_refused)
);

// ==== hdl/pvp_limit.sv ====
module pvp_limit
    import pvp_pkg::*;
(
    input wire logic signed [31:0] request,
    input wire logic [31:0] ctrl_max,
    input wire logic [31:0] ramp_max,
    output logic signed [31:0] limited
);

    // Clamp magnitude to the smaller maximum; maxima above the signed range saturate there.
    function automatic logic [31:0] pvp_min_u(input logic [31:0] a, input logic [31:0] b);
        pvp_min_u = (a < b) ? a : b;
    endfunction

    logic [31:0] lim_u;
    logic [31:0] lim_s;
    logic [32:0] mag;

    always_comb begin
        lim_u = pvp_min_u(ctrl_max, ramp_max);
        lim_s = pvp_min_u(lim_u, 32'h7FFFFFFF);
        mag = request[31] ? (33'h0 - {request[31], request}) : {1'b0, request};
        if (mag > {1'b0, lim_s}) begin
            limited = request[31] ? signed'(32'h0 - lim_s) : signed'(lim_s);
        end else begin
            limited = request;
        end
    end

endmodule

// ==== hdl/pvp_pkg.sv ====
package pvp_pkg;

    // Register offsets on the parameter port, as printed.
    localparam logic [15:0] PVP_OFS_VM_TGT_SPEED = 16'h1B1A;
    localparam logic [15:0] PVP_OFS_PM_TGT_POS = 16'h1B1C;
    localparam logic [15:0] PVP_OFS_PM_TGT_SPEED = 16'h1B1E;

    // Reset values and the minimum position speed.
    localparam logic [31:0] PVP_RST_VM_TGT_SPEED = 32'h00000000;
    localparam logic [31:0] PVP_RST_PM_TGT_POS = 32'h00000000;
    localparam logic [31:0] PVP_RST_PM_TGT_SPEED = 32'h0000003C;
    localparam logic [31:0] PVP_MIN_PM_TGT_SPEED = 32'h00000001;

    // Operating states that drive the status outputs.
    localparam logic [3:0] PVP_ST_READY = 4'h4;
    localparam logic [3:0] PVP_ST_SWITCHED_ON = 4'h5;
    localparam logic [3:0] PVP_ST_OP_ENABLED = 4'h6;

    // Mode commands from the fieldbus.
    localparam logic [1:0] PVP_CMD_NONE = 2'h0;
    localparam logic [1:0] PVP_CMD_VELOCITY = 2'h1;
    localparam logic [1:0] PVP_CMD_POSITION = 2'h2;

    // Position methods and relative references.
    localparam logic PVP_METHOD_RELATIVE = 1'b0;
    localparam logic PVP_METHOD_ABSOLUTE = 1'b1;
    localparam logic PVP_REF_PREV_TARGET = 1'b0;
    localparam logic PVP_REF_ACTUAL_POS = 1'b1;

    typedef enum logic [1:0] {
        PVP_MODE_IDLE,
        PVP_MODE_VELOCITY,
        PVP_MODE_POSITION
    } pvp_mode_e;

    // Parameter port write or read request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } pvp_preq_s;

    // Stop causes reported by the motion core.
    typedef struct packed {
        logic halt;
        logic quick_stop;
        logic error;
        logic standstill;
        logic target_reached;
    } pvp_stop_s;

endpackage

// ==== hdl/pvp_top.sv ====
// Function
// - No-fault output high in states 4, 5, 6.
// - Active output high only in state 6.
// - Velocity mode ends: standstill after halt/stop/error.
// - Velocity target clamped to both velocity maxima.
// - Velocity target signed 32-bit, reset 0, immediate.
// - Position mode: relative or absolute methods.
// - Position mode also ends at target standstill.
// - Target position signed 32-bit, bounded, immediate; here taken only at the next accepted start.
// - Position speed 1..max, reset 60, next move.
module pvp_top
    import pvp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic preq_wr,
    input wire logic preq_rd,
    input wire logic [15:0] preq_addr,
    input wire logic [31:0] preq_wdata,
    output logic [31:0] prsp_rdata,
    output logic prsp_valid,
    output logic prsp_err,
    input wire logic [1:0] mode_cmd,
    input wire logic move_start,
    input wire logic move_method,
    input wire logic rel_reference,
    input wire logic homed,
    input wire logic [3:0] op_state,
    input wire logic outputs_reassigned,
    input wire logic [31:0] ctrl_v_max,
    input wire logic [31:0] ramp_v_max,
    input wire logic signed [31:0] pos_min,
    input wire logic signed [31:0] pos_max,
    input wire logic signed [31:0] actual_pos,
    input wire logic stop_halt,
    input wire logic stop_quick,
    input wire logic stop_error,
    input wire logic standstill,
    input wire logic target_reached,
    output logic no_fault_output,
    output logic active_output,
    output logic [1:0] mode_active,
    output logic mode_ended,
    output logic signed [31:0] vel_setpoint,
    output logic signed [31:0] pos_setpoint,
    output logic [31:0] pos_speed,
    output logic move_go,
    output logic abs_refused
);

    // Request and stop bundles, mode state and the parameters as last written.
    pvp_preq_s preq;
    pvp_stop_s stops;
    pvp_mode_e mode_q;
    logic signed [31:0] vm_speed_q;
    logic signed [31:0] pm_pos_q;
    logic [31:0] pm_speed_q;
    logic signed [31:0] vel_limited;
    logic signed [31:0] pos_limited;
    logic [31:0] speed_limited;
    logic signed [31:0] prev_target_q;
    logic signed [31:0] goal;
    logic stopped_by_cause;
    logic mode_end_now;
    logic [31:0] lim_speed;
    logic move_request;
    logic move_blocked;

    // Bundle the port signals so that each concern reads one structure.
    assign preq = '{wr: preq_wr, rd: preq_rd, addr: preq_addr, wdata: preq_wdata};
    assign stops = '{halt: stop_halt, quick_stop: stop_quick, error: stop_error,
                     standstill: standstill, target_reached: target_reached};

    // Clamp a signed position into the active bounds.
    function automatic logic signed [31:0] pvp_clamp_pos(input logic signed [31:0] p,
                                                         input logic signed [31:0] lo,
                                                         input logic signed [31:0] hi);
        if (p < lo) begin
            pvp_clamp_pos = lo;
        end else if (p > hi) begin
            pvp_clamp_pos = hi;
        end else begin
            pvp_clamp_pos = p;
        end
    endfunction

    // Smaller of two unsigned values.
    function automatic logic [31:0] pvp_umin(input logic [31:0] a, input logic [31:0] b);
        pvp_umin = (a < b) ? a : b;
    endfunction

    // State 6 alone lets a mode run and lights the active output.
    function automatic logic pvp_op_enabled(input logic [3:0] st);
        pvp_op_enabled = (st == PVP_ST_OP_ENABLED);
    endfunction

    // States 4, 5 and 6 all count as free of faults.
    function automatic logic pvp_no_fault_state(input logic [3:0] st);
        pvp_no_fault_state = (st == PVP_ST_READY) || (st == PVP_ST_SWITCHED_ON) || pvp_op_enabled(st);
    endfunction

    pvp_limit u_vel_limit (
        .request(vm_speed_q),
        .ctrl_max(ctrl_v_max),
        .ramp_max(ramp_v_max),
        .limited(vel_limited)
    );

    // Position speed shares both maxima but stays unsigned and never drops below one.
    always_comb begin
        lim_speed = pvp_umin(pvp_umin(pm_speed_q, ctrl_v_max), ramp_v_max);
        speed_limited = (lim_speed < PVP_MIN_PM_TGT_SPEED) ? PVP_MIN_PM_TGT_SPEED : lim_speed;
    end

    // Bounds follow scaling and software limits supplied by the motion core.
    assign pos_limited = pvp_clamp_pos(pm_pos_q, pos_min, pos_max);

    // Relative moves add to the previous target or the actual position; absolute stands alone.
    always_comb begin
        if (move_method == PVP_METHOD_ABSOLUTE) begin
            goal = pos_limited;
        end else if (rel_reference == PVP_REF_ACTUAL_POS) begin
            goal = pvp_clamp_pos(32'(actual_pos + pos_limited), pos_min, pos_max);
        end else begin
            goal = pvp_clamp_pos(32'(prev_target_q + pos_limited), pos_min, pos_max);
        end
    end

    // Parameter writes; an invalid zero speed is ignored so the last good value stands.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vm_speed_q <= signed'(PVP_RST_VM_TGT_SPEED);
            pm_pos_q <= signed'(PVP_RST_PM_TGT_POS);
            pm_speed_q <= PVP_RST_PM_TGT_SPEED;
        end else if (preq.wr) begin
            case (preq.addr)
                PVP_OFS_VM_TGT_SPEED: begin
                    vm_speed_q <= signed'(preq.wdata);
                end
                PVP_OFS_PM_TGT_POS: begin
                    pm_pos_q <= signed'(preq.wdata);
                end
                PVP_OFS_PM_TGT_SPEED: begin
                    if (preq.wdata >= PVP_MIN_PM_TGT_SPEED) begin
                        pm_speed_q <= preq.wdata;
                    end
                end
                default: begin
                    // Unmapped offsets leave every parameter untouched.
                end
            endcase
        end
    end

    // Read answer one cycle after the request; unmapped offsets answer with an error.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prsp_rdata <= 32'h00000000;
            prsp_valid <= 1'b0;
            prsp_err <= 1'b0;
        end else begin
            prsp_valid <= preq.rd | preq.wr;
            prsp_err <= 1'b0;
            prsp_rdata <= 32'h00000000;
            // Writes answer too, with zero data, so the master sees every request taken.
            if (preq.rd | preq.wr) begin
                case (preq.addr)
                    PVP_OFS_VM_TGT_SPEED: begin
                        prsp_rdata <= preq.rd ? vm_speed_q : 32'h00000000;
                    end
                    PVP_OFS_PM_TGT_POS: begin
                        prsp_rdata <= preq.rd ? pm_pos_q : 32'h00000000;
                    end
                    PVP_OFS_PM_TGT_SPEED: begin
                        prsp_rdata <= preq.rd ? pm_speed_q : 32'h00000000;
                    end
                    default: begin
                        prsp_err <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Status outputs follow the operating state unless configuration reassigned them.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            no_fault_output <= 1'b0;
            active_output <= 1'b0;
        end else if (outputs_reassigned) begin
            // Reassigned outputs belong to another function, so this block holds them low.
            no_fault_output <= 1'b0;
            active_output <= 1'b0;
        end else begin
            no_fault_output <= pvp_no_fault_state(op_state);
            active_output <= pvp_op_enabled(op_state);
        end
    end

    // End conditions: standstill plus a cause; position mode also accepts target reached.
    assign stopped_by_cause = stops.halt | stops.quick_stop | stops.error;
    always_comb begin
        case (mode_q)
            PVP_MODE_VELOCITY: mode_end_now = stops.standstill & stopped_by_cause;
            PVP_MODE_POSITION: mode_end_now = stops.standstill &
                                              (stopped_by_cause | stops.target_reached);
            default: mode_end_now = 1'b0;
        endcase
    end

    // Mode sequencer; modes are entered only on a fieldbus command in state 6.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_q <= PVP_MODE_IDLE;
            mode_ended <= 1'b0;
        end else begin
            mode_ended <= 1'b0;
            case (mode_q)
                PVP_MODE_IDLE: begin
                    // A mode is entered only here, on a command; the block never starts one by itself.
                    if (pvp_op_enabled(op_state) && mode_cmd == PVP_CMD_VELOCITY) begin
                        mode_q <= PVP_MODE_VELOCITY;
                    end else if (pvp_op_enabled(op_state) && mode_cmd == PVP_CMD_POSITION) begin
                        mode_q <= PVP_MODE_POSITION;
                    end
                end
                PVP_MODE_VELOCITY, PVP_MODE_POSITION: begin
                    // Leaving state 6 also ends the mode, since the motor no longer follows a setpoint.
                    if (mode_end_now || !pvp_op_enabled(op_state)) begin
                        mode_q <= PVP_MODE_IDLE;
                        mode_ended <= 1'b1;
                    end
                end
                default: begin
                    mode_q <= PVP_MODE_IDLE;
                end
            endcase
        end
    end

    // Mode code mirrors the sequencer one edge later so that the output comes from a flip-flop.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_active <= PVP_CMD_NONE;
        end else begin
            case (mode_q)
                PVP_MODE_VELOCITY: begin
                    mode_active <= PVP_CMD_VELOCITY;
                end
                PVP_MODE_POSITION: begin
                    mode_active <= PVP_CMD_POSITION;
                end
                default: begin
                    mode_active <= PVP_CMD_NONE;
                end
            endcase
        end
    end

    // Velocity setpoint is live: a new target reaches the output on the next edge.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vel_setpoint <= 32'sh0;
        end else if (mode_q == PVP_MODE_VELOCITY) begin
            vel_setpoint <= vel_limited;
        end else begin
            vel_setpoint <= 32'sh0;
        end
    end

    // Absolute moves without a zero point would run to an undefined place, so they are refused.
    assign move_request = (mode_q == PVP_MODE_POSITION) && move_start;
    assign move_blocked = (move_method == PVP_METHOD_ABSOLUTE) && !homed;

    // Each start in position mode gives one pulse, accepted or refused, never both.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            move_go <= 1'b0;
            abs_refused <= 1'b0;
        end else begin
            move_go <= move_request && !move_blocked;
            abs_refused <= move_request && move_blocked;
        end
    end

    // Goal and speed latch only on an accepted start, so a speed written mid-move waits.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pos_setpoint <= 32'sh0;
            pos_speed <= PVP_RST_PM_TGT_SPEED;
            prev_target_q <= 32'sh0;
        end else if (move_request && !move_blocked) begin
            pos_setpoint <= goal;
            // The goal just taken is the reference for the next relative move.
            prev_target_q <= goal;
            pos_speed <= speed_limited;
        end
    end

endmodule
